//--- shared/lane_ctrl_pkg.sv
// constants and types for the alternate-mode lane control block
package lane_ctrl_pkg;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ROUTE_OFF, ROUTE_USB, ROUTE_DISP, ROUTE_PCIE} route_t;
   typedef enum logic [1:0] {TERM_IN_PD, TERM_IN_50, TERM_IN_BIAS} in_term_t;
   typedef enum logic [1:0] {TERM_OUT_HIZ, TERM_OUT_50, TERM_OUT_4K5} out_term_t;

   // ----------------------------------------------------------------
   // reset values and strap decodes
   // ----------------------------------------------------------------
   localparam logic [3:0] PRESET_RST = 4'h0;
   localparam logic [3:0] BOOST_REG_RST = 4'h0;
   localparam logic [3:0] BOOST_LVL_L = 4'h0;
   localparam logic [3:0] BOOST_LVL_R = 4'h5;
   localparam logic [3:0] BOOST_LVL_F = 4'ha;
   localparam logic [3:0] BOOST_LVL_H = 4'hf;
   localparam logic [1:0] LVL_L = 2'h0;
   localparam logic [1:0] LVL_R = 2'h1;
   localparam logic [1:0] LVL_F = 2'h2;
   localparam logic [1:0] LVL_H = 2'h3;
   localparam logic [1:0] GAIN_M1P5 = 2'h0;
   localparam logic [1:0] GAIN_0 = 2'h1;
   localparam logic [1:0] GAIN_P1 = 2'h2;
   localparam logic [1:0] GAIN_P2P5 = 2'h3;
   localparam logic [1:0] SWING_900 = 2'h0;
   localparam logic [1:0] SWING_1000 = 2'h1;
   localparam logic [1:0] SWING_1100 = 2'h2;
   localparam logic [1:0] SWING_1200 = 2'h3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int IDLE_TIME_MS = 6;
   localparam int IDLE_CYCLES = IDLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int DEBOUNCE_CYCLES = 1000;
   localparam int DETECT_CYCLES = 16;
   localparam int CNT_W = 23;

endpackage : lane_ctrl_pkg

//--- rtl/usb_chan_pm.sv
// per-channel low-power, receiver detect and unplug state machine
`timescale 1ns/1ns
module usb_chan_pm #(
   parameter int IDLE_CYC = lane_ctrl_pkg::IDLE_CYCLES
) (
   input wire logic clk, // clock
   input wire logic rst_b, // sync reset, low
   input wire logic chan_on, // channel routed as usb
   input wire logic det_en, // far load detect enabled
   input wire logic sig_active, // signal detector activity
   input wire logic load_found, // far load evaluation result
   output lane_ctrl_pkg::in_term_t in_term, // input termination
   output lane_ctrl_pkg::out_term_t out_term, // output termination
   output logic active // channel in u0
);
   typedef enum logic [2:0] {S_OFF, S_DETECT, S_ACTIVE, S_LOWPWR, S_UNPLUG} pm_state_t;
   pm_state_t state_q, state_d;
   logic [lane_ctrl_pkg::CNT_W-1:0] cnt_q, cnt_d;
   lane_ctrl_pkg::in_term_t in_term_q, in_term_d;
   wire idle_done = (cnt_q >= lane_ctrl_pkg::CNT_W'(IDLE_CYC - 1));
   wire det_done = (cnt_q >= lane_ctrl_pkg::CNT_W'(lane_ctrl_pkg::DETECT_CYCLES - 1));
   wire [lane_ctrl_pkg::CNT_W-1:0] cnt_inc = cnt_q + lane_ctrl_pkg::CNT_W'(1);

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_inc;
      in_term_d = in_term_q;
      unique case (state_q)
         S_OFF:
         begin
            cnt_d = '0;
            in_term_d = lane_ctrl_pkg::TERM_IN_PD;
            if (chan_on)
            begin
               state_d = det_en ? S_DETECT : S_ACTIVE;
            end
         end
         S_DETECT:
            if (det_done)
            begin
               cnt_d = '0;
               // termination reported only once evaluation ends
               in_term_d = load_found ? lane_ctrl_pkg::TERM_IN_50
                  : lane_ctrl_pkg::TERM_IN_PD;
               state_d = load_found ? S_LOWPWR : S_UNPLUG;
            end
         S_ACTIVE:
         begin
            cnt_d = '0;
            if (!sig_active)
               state_d = S_LOWPWR;
         end
         S_LOWPWR:
            if (sig_active)
               state_d = S_ACTIVE;
            else if (idle_done && det_en)
            begin
               cnt_d = '0;
               state_d = S_DETECT;
            end
         S_UNPLUG:
            if (sig_active)
               state_d = S_ACTIVE;
            else if (idle_done)
            begin
               cnt_d = '0;
               state_d = S_DETECT;
            end
         default:
            state_d = S_OFF;
      endcase
      if (state_d == S_ACTIVE)
         in_term_d = lane_ctrl_pkg::TERM_IN_50;
      if (!chan_on)
      begin
         state_d = S_OFF;
         cnt_d = '0;
         in_term_d = lane_ctrl_pkg::TERM_IN_PD;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_q <= S_OFF;
         cnt_q <= '0;
         in_term_q <= lane_ctrl_pkg::TERM_IN_PD;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         in_term_q <= in_term_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         in_term <= lane_ctrl_pkg::TERM_IN_PD;
         out_term <= lane_ctrl_pkg::TERM_OUT_HIZ;
         active <= 1'b0;
      end
      else
      begin
         in_term <= in_term_d;
         out_term <= (state_d == S_OFF) ? lane_ctrl_pkg::TERM_OUT_HIZ
            : (state_d == S_ACTIVE) ? lane_ctrl_pkg::TERM_OUT_50
            : lane_ctrl_pkg::TERM_OUT_4K5;
         active <= (state_d == S_ACTIVE);
      end
   end
endmodule : usb_chan_pm

//--- rtl/lane_ctrl.sv
// preset decode, plug gating, strap decode and usb power control
`timescale 1ns/1ns
module lane_ctrl #(
   parameter int DEBOUNCE_CYC = lane_ctrl_pkg::DEBOUNCE_CYCLES,
   parameter int IDLE_CYC = lane_ctrl_pkg::IDLE_CYCLES
) (
   input wire logic clk, // clock
   input wire logic rst_b, // sync reset, low
   input wire logic chip_enable, // chip enable, low powers down
   input wire logic reg_ctrl_sel, // high register control, low straps
   input wire logic [2:0] lane_preset_code, // preset straps
   input wire logic [3:0] reg_preset, // preset register field
   input wire logic sink_plug_detect_in, // plug detect pin
   input wire logic plug_active_low, // plug polarity select
   input wire logic plug_pin_bypass_n, // one: outputs ignore plug pin
   input wire logic [1:0] boost_strap_lvl, // 4-level boost strap
   input wire logic [1:0] gain_strap_lvl, // 4-level flat gain strap
   input wire logic swing_select, // 2-level swing strap
   input wire logic [15:0] reg_boost, // 4 x boost field
   input wire logic [7:0] reg_gain, // 4 x gain field
   input wire logic [7:0] reg_swing, // 4 x conn_swing_field
   input wire logic far_load_detect_enable, // detect enable pin
   input wire logic [1:0] sig_active, // per-host-channel activity
   input wire logic [1:0] load_found, // per-channel load result
   output lane_ctrl_pkg::route_t [1:0] pair_route, // route per pair
   output logic aux_swap, // aux on sideband 2/1
   output logic aux_connect, // aux connected
   output logic [3:0] lane_out_en, // per lane output enable
   output logic [15:0] rx_boost_code, // 4 x boost code
   output logic [7:0] flat_gain_code, // 4 x gain code
   output logic [7:0] swing_code, // 4 x swing code
   output logic [1:0] usb_active, // usb channel in u0
   output lane_ctrl_pkg::in_term_t [1:0] in_term, // input terminations
   output lane_ctrl_pkg::out_term_t [1:0] out_term, // output terminations
   output logic display_standby // standby, plug deasserted
);
   // ----------------------------------------------------------------
   // power-down reset and strap capture
   // ----------------------------------------------------------------
   wire run_b = rst_b & chip_enable;
   logic run_q;
   logic [2:0] strap_preset_q;
   logic [1:0] boost_lvl_q, gain_lvl_q;
   logic swing_lvl_q;

   // straps sampled once on leaving power-down, not tracked afterwards
   always_ff @(posedge clk)
   begin
      if (!run_b)
         run_q <= 1'b0;
      else
         run_q <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!run_b)
      begin
         strap_preset_q <= 3'h0;
         boost_lvl_q <= lane_ctrl_pkg::LVL_F;
         gain_lvl_q <= lane_ctrl_pkg::LVL_F;
         swing_lvl_q <= 1'b1;
      end
      else if (!run_q)
      begin
         strap_preset_q <= lane_preset_code;
         boost_lvl_q <= boost_strap_lvl;
         gain_lvl_q <= gain_strap_lvl;
         swing_lvl_q <= swing_select;
      end
   end

   // ----------------------------------------------------------------
   // preset select
   // ----------------------------------------------------------------
   // register path reaches all sixteen presets, straps only the low eight
   wire [3:0] preset = reg_ctrl_sel ? reg_preset : {1'b0, strap_preset_q};

   lane_ctrl_pkg::route_t r1_d, r2_d;
   logic swap_d, aux_d;
   logic [1:0] plug_gate_d; // bit i: pair i+1 obeys plug

   always_comb
   begin
      r1_d = lane_ctrl_pkg::ROUTE_OFF;
      r2_d = lane_ctrl_pkg::ROUTE_OFF;
      swap_d = 1'b0;
      aux_d = 1'b0;
      plug_gate_d = 2'b00;
      // lanes never swap; flip is aux polarity alone
      unique case (preset)
         4'h2, 4'h3:
         begin
            r1_d = lane_ctrl_pkg::ROUTE_DISP;
            r2_d = lane_ctrl_pkg::ROUTE_DISP;
            aux_d = 1'b1;
            swap_d = preset[0];
            plug_gate_d = 2'b11;
         end
         4'h4: r1_d = lane_ctrl_pkg::ROUTE_USB;
         4'h5: r2_d = lane_ctrl_pkg::ROUTE_USB;
         4'h6, 4'h9:
         begin
            r1_d = lane_ctrl_pkg::ROUTE_USB;
            r2_d = lane_ctrl_pkg::ROUTE_DISP;
            aux_d = 1'b1;
            swap_d = preset[0];
            plug_gate_d = 2'b10;
         end
         4'h7:
         begin
            r1_d = lane_ctrl_pkg::ROUTE_DISP;
            r2_d = lane_ctrl_pkg::ROUTE_USB;
            aux_d = 1'b1;
            swap_d = 1'b1;
            plug_gate_d = 2'b01;
         end
         4'h8:
         begin
            r1_d = lane_ctrl_pkg::ROUTE_DISP;
            r2_d = lane_ctrl_pkg::ROUTE_USB;
            aux_d = 1'b1;
            plug_gate_d = 2'b01;
         end
         4'ha, 4'hb:
         begin
            r1_d = lane_ctrl_pkg::ROUTE_DISP;
            r2_d = lane_ctrl_pkg::ROUTE_DISP;
            aux_d = 1'b1;
            swap_d = preset[0];
            plug_gate_d = 2'b11;
         end
         4'hc:
         begin
            r1_d = lane_ctrl_pkg::ROUTE_USB;
            r2_d = lane_ctrl_pkg::ROUTE_USB;
         end
         4'hd:
         begin
            r1_d = lane_ctrl_pkg::ROUTE_PCIE;
            r2_d = lane_ctrl_pkg::ROUTE_PCIE;
         end
         4'he:
         begin
            r1_d = lane_ctrl_pkg::ROUTE_USB;
            r2_d = lane_ctrl_pkg::ROUTE_PCIE;
         end
         4'hf:
         begin
            r1_d = lane_ctrl_pkg::ROUTE_PCIE;
            r2_d = lane_ctrl_pkg::ROUTE_USB;
         end
         default:
         begin
            r1_d = lane_ctrl_pkg::ROUTE_OFF;
            r2_d = lane_ctrl_pkg::ROUTE_OFF;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // plug detect polarity and debounce
   // ----------------------------------------------------------------
   wire plug_raw = sink_plug_detect_in ^ plug_active_low;
   logic plug_q;
   logic [lane_ctrl_pkg::CNT_W-1:0] deb_q;
   wire deb_done = (deb_q >= lane_ctrl_pkg::CNT_W'(DEBOUNCE_CYC - 1));

   // any high sample restarts the count, so brief glitches never drop the link
   always_ff @(posedge clk)
   begin
      if (!run_b)
      begin
         plug_q <= 1'b0;
         deb_q <= '0;
      end
      else if (plug_raw)
      begin
         plug_q <= 1'b1;
         deb_q <= '0;
      end
      else if (plug_q)
      begin
         deb_q <= deb_done ? '0 : deb_q + lane_ctrl_pkg::CNT_W'(1);
         plug_q <= !deb_done;
      end
   end

   // bypass forces display on; software sets it where pin must not govern
   wire plug_ok = plug_pin_bypass_n | plug_q;

   function automatic logic pair_en(input lane_ctrl_pkg::route_t r, input gated, input ok);
      pair_en = (r != lane_ctrl_pkg::ROUTE_OFF) && (!gated || r != lane_ctrl_pkg::ROUTE_DISP || ok);
   endfunction : pair_en

   wire en1 = pair_en(r1_d, plug_gate_d[0], plug_ok);
   wire en2 = pair_en(r2_d, plug_gate_d[1], plug_ok);
   wire any_disp = (plug_gate_d != 2'b00);

   // ----------------------------------------------------------------
   // equalizer, gain, swing decode
   // ----------------------------------------------------------------
   function automatic logic [3:0] boost_of(input logic [1:0] lvl);
      unique case (lvl)
         lane_ctrl_pkg::LVL_L: boost_of = lane_ctrl_pkg::BOOST_LVL_L;
         lane_ctrl_pkg::LVL_R: boost_of = lane_ctrl_pkg::BOOST_LVL_R;
         lane_ctrl_pkg::LVL_F: boost_of = lane_ctrl_pkg::BOOST_LVL_F;
         lane_ctrl_pkg::LVL_H: boost_of = lane_ctrl_pkg::BOOST_LVL_H;
      endcase
   endfunction : boost_of

   function automatic logic [1:0] gain_of(input logic [1:0] lvl);
      unique case (lvl)
         lane_ctrl_pkg::LVL_R: gain_of = lane_ctrl_pkg::GAIN_M1P5;
         lane_ctrl_pkg::LVL_F: gain_of = lane_ctrl_pkg::GAIN_0;
         lane_ctrl_pkg::LVL_L: gain_of = lane_ctrl_pkg::GAIN_P1;
         lane_ctrl_pkg::LVL_H: gain_of = lane_ctrl_pkg::GAIN_P2P5;
      endcase
   endfunction : gain_of

   // strap swing: usb 900/1000, display 1100/1200 by route
   function automatic logic [1:0] swing_of(input logic lvl, input lane_ctrl_pkg::route_t r);
      if (r == lane_ctrl_pkg::ROUTE_DISP)
         swing_of = lvl ? lane_ctrl_pkg::SWING_1200 : lane_ctrl_pkg::SWING_1100;
      else
         swing_of = lvl ? lane_ctrl_pkg::SWING_1000 : lane_ctrl_pkg::SWING_900;
   endfunction : swing_of

   wire [15:0] boost_d;
   wire [7:0] gain_d;
   wire [7:0] swing_d;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_chan
         // channels 0,1 sit on pair 2, channels 2,3 on pair 1
         assign boost_d[gi*4 +: 4] = reg_ctrl_sel ? reg_boost[gi*4 +: 4]
            : boost_of(boost_lvl_q);
         assign gain_d[gi*2 +: 2] = reg_ctrl_sel ? reg_gain[gi*2 +: 2]
            : gain_of(gain_lvl_q);
         assign swing_d[gi*2 +: 2] = reg_ctrl_sel ? reg_swing[gi*2 +: 2]
            : swing_of(swing_lvl_q, (gi < 2) ? r2_d : r1_d);
      end
   endgenerate

   // ----------------------------------------------------------------
   // usb channel power state
   // ----------------------------------------------------------------
   wire det_en = far_load_detect_enable;
   wire [1:0] usb_on = {r2_d == lane_ctrl_pkg::ROUTE_USB, r1_d == lane_ctrl_pkg::ROUTE_USB};
   logic [1:0] usb_act;
   lane_ctrl_pkg::in_term_t [1:0] in_term_w;
   lane_ctrl_pkg::out_term_t [1:0] out_term_w;

   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_usb
         usb_chan_pm #(
            .IDLE_CYC(IDLE_CYC)
         ) u_pm (
            .clk(clk),
            .rst_b(run_b),
            .chan_on(usb_on[gi]),
            .det_en(det_en),
            .sig_active(sig_active[gi]),
            .load_found(load_found[gi]),
            .in_term(in_term_w[gi]),
            .out_term(out_term_w[gi]),
            .active(usb_act[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!run_b)
      begin
         pair_route <= '{lane_ctrl_pkg::ROUTE_OFF, lane_ctrl_pkg::ROUTE_OFF};
         aux_swap <= 1'b0;
         aux_connect <= 1'b0;
         lane_out_en <= 4'h0;
         rx_boost_code <= {4{lane_ctrl_pkg::BOOST_REG_RST}};
         flat_gain_code <= {4{lane_ctrl_pkg::GAIN_0}};
         swing_code <= {4{lane_ctrl_pkg::SWING_1200}};
         display_standby <= 1'b0;
      end
      else
      begin
         pair_route <= '{r2_d, r1_d};
         aux_swap <= swap_d;
         aux_connect <= aux_d && plug_ok;
         lane_out_en <= {en1, en1, en2, en2};
         rx_boost_code <= boost_d;
         flat_gain_code <= gain_d;
         swing_code <= swing_d;
         display_standby <= any_disp && !plug_ok;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!run_b)
      begin
         usb_active <= 2'b00;
         in_term <= '{lane_ctrl_pkg::TERM_IN_PD, lane_ctrl_pkg::TERM_IN_PD};
         out_term <= '{lane_ctrl_pkg::TERM_OUT_HIZ, lane_ctrl_pkg::TERM_OUT_HIZ};
      end
      else
      begin
         usb_active <= usb_act;
         in_term <= in_term_w;
         out_term <= out_term_w;
      end
   end
endmodule : lane_ctrl

//--- bench/lane_ctrl_checker.sv
// concurrent checks on the lane control ports
`timescale 1ns/1ns
module lane_ctrl_checker #(
   parameter int DEBOUNCE_CYC = 8
) (
   input wire logic clk, // clock
   input wire logic rst_b, // reset
   input wire logic chip_enable, // enable
   input wire logic reg_ctrl_sel, // control select
   input wire logic [3:0] reg_preset, // preset field
   input wire logic sink_plug_detect_in, // plug pin
   input wire logic plug_active_low, // polarity
   input wire logic plug_pin_bypass_n, // bypass
   input wire logic [1:0] sig_active, // activity
   input wire lane_ctrl_pkg::route_t [1:0] pair_route, // routes
   input wire logic aux_swap, // aux swap
   input wire logic aux_connect, // aux on
   input wire logic [3:0] lane_out_en, // enables
   input wire logic [1:0] usb_active, // u0
   input wire lane_ctrl_pkg::in_term_t [1:0] in_term, // in term
   input wire lane_ctrl_pkg::out_term_t [1:0] out_term, // out term
   input wire logic display_standby // standby
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic [15:0] low_cnt_q;
   wire plug_ok = sink_plug_detect_in ^ plug_active_low;
   wire live = chip_enable && reg_ctrl_sel;
   wire disp2 = live && reg_preset == 4'h2 && !plug_pin_bypass_n;
   // cycles of plug deasserted with the display preset steady
   always_ff @(posedge clk)
   begin
      if (!rst_b || plug_ok || !disp2)
         low_cnt_q <= 16'h0;
      else if (low_cnt_q != 16'hffff)
         low_cnt_q <= low_cnt_q + 16'h1;
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_pd_all_off: assert property (!chip_enable |=> pair_route == 4'h0 && lane_out_en == 4'h0 &&
      !aux_connect && in_term == 4'h0 && out_term == 4'h0)
      else $error("outputs not off in power down");
   chk_flip_aux_only: assert property (live && $past(chip_enable) && reg_preset == 4'h3
      |=> aux_swap && pair_route == 4'ha)
      else $error("flip preset moved lanes");
   chk_no_aux_pcie: assert property (live && $past(chip_enable) && reg_preset[3:2] == 2'h3
      |=> !aux_connect)
      else $error("aux connected in usb/pcie preset");
   chk_plug_fast: assert property (disp2 && plug_ok ##1 disp2 |=> lane_out_en == 4'hf)
      else $error("plug assert not taken at once");
   chk_bypass_on: assert property (live && $past(chip_enable) && reg_preset == 4'h2 &&
      plug_pin_bypass_n |=> lane_out_en == 4'hf)
      else $error("bypass did not enable display");
   chk_debounce_hold: assert property (disp2 && low_cnt_q != 16'h0 && low_cnt_q < DEBOUNCE_CYC
      && $past(lane_out_en) == 4'hf |-> lane_out_en == 4'hf)
      else $error("display dropped inside debounce");
   chk_deassert_off: assert property (disp2 && low_cnt_q > DEBOUNCE_CYC + 2
      |-> lane_out_en == 4'h0 && display_standby)
      else $error("no standby after debounce");
   chk_wake_fast: assert property (chip_enable && pair_route[0] == lane_ctrl_pkg::ROUTE_USB &&
      in_term[0] == lane_ctrl_pkg::TERM_IN_50 && sig_active[0] && !usb_active[0]
      |-> ##[1:4] usb_active[0])
      else $error("low power channel did not wake");
   chk_u0_term: assert property (usb_active[0] |-> out_term[0] == lane_ctrl_pkg::TERM_OUT_50 &&
      in_term[0] == lane_ctrl_pkg::TERM_IN_50)
      else $error("u0 terminations wrong");
   cov_debounce: cover property (disp2 && low_cnt_q == DEBOUNCE_CYC);
   cov_wake: cover property (usb_active[0]);
   cov_flip: cover property (aux_swap && aux_connect);
endmodule : lane_ctrl_checker

//--- bench/far_end_model.sv
// far-end receiver and host traffic model for both pairs
`timescale 1ns/1ns
module far_end_model (
   input wire logic clk, // clock
   input wire logic [1:0] load_present, // receiver attached
   input wire logic [1:0] burst, // traffic on the lane
   input wire lane_ctrl_pkg::out_term_t [1:0] out_term, // block output term
   output logic [1:0] sig_active, // activity seen
   output logic [1:0] load_found // detect result
);
   // a load is only seen while the transmitter is not floating
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 2; i++)
      begin
         load_found[i] <= load_present[i] && out_term[i] != lane_ctrl_pkg::TERM_OUT_HIZ;
         sig_active[i] <= burst[i];
      end
   end
endmodule : far_end_model

//--- bench/tb_top.sv
// self-checking bench for the lane control block
`timescale 1ns/1ns
module tb_top;
   localparam int DEB = 8;
   localparam logic [5:0] MAP [16] = '{6'h00, 6'h00, 6'h2a, 6'h3a, 6'h01, 6'h04, 6'h29, 6'h36,
      6'h26, 6'h39, 6'h2a, 6'h3a, 6'h05, 6'h0f, 6'h0d, 6'h07};
   localparam logic [3:0] BST [4] = '{4'h0, 4'h5, 4'ha, 4'hf};
   localparam logic [1:0] GN [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
   logic clk = 0, rst_b = 0, chip_enable = 1, reg_ctrl_sel = 1, sink_plug_detect_in = 0;
   logic plug_active_low = 0, plug_pin_bypass_n = 1, swing_select = 1, far_load_detect_enable = 1;
   logic [2:0] lane_preset_code = 3'h0;
   logic [3:0] reg_preset = 4'h0;
   logic [1:0] boost_strap_lvl = 2'h2, gain_strap_lvl = 2'h2, sig_active, load_found;
   logic [1:0] load_present = 2'h1, burst = 2'h0;
   logic [15:0] reg_boost = 16'h0;
   logic [7:0] reg_gain = 8'h55, reg_swing = 8'hff, flat_gain_code, swing_code;
   lane_ctrl_pkg::route_t [1:0] pair_route;
   lane_ctrl_pkg::in_term_t [1:0] in_term;
   lane_ctrl_pkg::out_term_t [1:0] out_term;
   logic aux_swap, aux_connect, display_standby;
   logic [3:0] lane_out_en;
   logic [15:0] rx_boost_code;
   logic [1:0] usb_active;
   int bad_count = 0, checks_done = 0, i;
   always #5 clk = ~clk;
   lane_ctrl #(.DEBOUNCE_CYC(DEB), .IDLE_CYC(20)) uut (.clk(clk), .rst_b(rst_b),
      .chip_enable(chip_enable), .reg_ctrl_sel(reg_ctrl_sel), .lane_preset_code(lane_preset_code),
      .reg_preset(reg_preset), .sink_plug_detect_in(sink_plug_detect_in),
      .plug_active_low(plug_active_low), .plug_pin_bypass_n(plug_pin_bypass_n),
      .boost_strap_lvl(boost_strap_lvl), .gain_strap_lvl(gain_strap_lvl),
      .swing_select(swing_select), .reg_boost(reg_boost), .reg_gain(reg_gain),
      .reg_swing(reg_swing), .far_load_detect_enable(far_load_detect_enable),
      .sig_active(sig_active), .load_found(load_found), .pair_route(pair_route),
      .aux_swap(aux_swap), .aux_connect(aux_connect), .lane_out_en(lane_out_en),
      .rx_boost_code(rx_boost_code), .flat_gain_code(flat_gain_code), .swing_code(swing_code),
      .usb_active(usb_active), .in_term(in_term), .out_term(out_term),
      .display_standby(display_standby));
   far_end_model far (.clk(clk), .load_present(load_present), .burst(burst),
      .out_term(out_term), .sig_active(sig_active), .load_found(load_found));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic power_cycle();
      chip_enable = 0;
      cyc(2);
      chip_enable = 1;
      cyc(3);
   endtask : power_cycle
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_sim
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_powerdown();
      chip_enable = 0;
      cyc(2);
      chk("route", 16'h0, {aux_connect, pair_route, lane_out_en});
      chk("boost", 16'h0, rx_boost_code);
      chk("gain swing", 16'h55ff, {flat_gain_code, swing_code});
      chk("terms", 16'h0, {in_term, out_term});
      chip_enable = 1;
      $display("test_powerdown done");
   endtask : test_powerdown
   task automatic test_presets();
      plug_pin_bypass_n = 1;
      for (int p = 0; p < 16; p++)
      begin
         reg_preset = p[3:0];
         cyc(2);
         chk("preset map", {10'h0, MAP[p]}, {aux_connect, aux_swap, pair_route});
      end
      $display("test_presets done");
   endtask : test_presets
   task automatic test_plug();
      reg_preset = 4'h2;
      plug_pin_bypass_n = 0;
      sink_plug_detect_in = 1;
      cyc(2);
      chk("plug rise", 16'hf, lane_out_en);
      sink_plug_detect_in = 0;
      cyc(DEB - 2);
      sink_plug_detect_in = 1;
      cyc(1);
      sink_plug_detect_in = 0;
      cyc(DEB - 2);
      chk("debounce", 16'hf, lane_out_en);
      cyc(6);
      chk("standby", 16'h10, {display_standby, lane_out_en});
      plug_active_low = 1;
      cyc(2);
      chk("low polarity", 16'hf, lane_out_en);
      sink_plug_detect_in = 1;
      plug_pin_bypass_n = 1;
      cyc(DEB + 4);
      chk("bypass", 16'hf, lane_out_en);
      plug_active_low = 0;
      $display("test_plug done");
   endtask : test_plug
   task automatic test_straps();
      reg_ctrl_sel = 0;
      lane_preset_code = 3'h6;
      swing_select = 0;
      for (int l = 0; l < 4; l++)
      begin
         boost_strap_lvl = l[1:0];
         gain_strap_lvl = l[1:0];
         power_cycle();
         chk("strap boost", {4{BST[l]}}, rx_boost_code);
         chk("strap gain", {8'h0, {4{GN[l]}}}, flat_gain_code);
      end
      chk("strap swing", 16'h0a, swing_code);
      chk("strap preset", 16'h29, {aux_connect, aux_swap, pair_route});
      lane_preset_code = 3'h2;
      swing_select = 1;
      cyc(3);
      chk("frozen", 16'h29, {aux_connect, aux_swap, pair_route});
      lane_preset_code = 3'h6;
      power_cycle();
      chk("strap swing hi", 16'h5f, swing_code);
      reg_ctrl_sel = 1;
      reg_preset = 4'h9;
      reg_boost = 16'h1234;
      reg_gain = 8'h9c;
      reg_swing = 8'he4;
      boost_strap_lvl = 2'h3;
      cyc(2);
      chk("reg boost", 16'h1234, rx_boost_code);
      chk("reg gain swing", 16'h9ce4, {flat_gain_code, swing_code});
      chk("reg preset", 16'h39, {aux_connect, aux_swap, pair_route});
      $display("test_straps done");
   endtask : test_straps
   task automatic test_usb();
      reg_preset = 4'h4;
      power_cycle();
      i = 0;
      while (i < 40 && in_term[0] !== lane_ctrl_pkg::TERM_IN_50)
      begin
         cyc(1);
         i++;
      end
      chk("low power", {2'h0, lane_ctrl_pkg::TERM_OUT_4K5}, {usb_active, out_term[0]});
      chk("low power term", lane_ctrl_pkg::TERM_IN_50, in_term[0]);
      burst = 2'h1;
      cyc(6);
      chk("wake", 16'h1, {14'h0, usb_active});
      burst = 2'h0;
      load_present = 2'h0;
      i = 0;
      while (i < 60 && in_term[0] !== lane_ctrl_pkg::TERM_IN_PD)
      begin
         cyc(1);
         i++;
      end
      chk("redetect", lane_ctrl_pkg::TERM_IN_PD, in_term[0]);
      chk("unplug", 16'h0, {14'h0, usb_active});
      load_present = 2'h1;
      i = 0;
      while (i < 60 && in_term[0] !== lane_ctrl_pkg::TERM_IN_50)
      begin
         cyc(1);
         i++;
      end
      chk("poll", lane_ctrl_pkg::TERM_IN_50, in_term[0]);
      far_load_detect_enable = 0;
      burst = 2'h1;
      power_cycle();
      chk("no detect", 16'h1, {14'h0, usb_active});
      $display("test_usb done");
   endtask : test_usb
   initial
   begin
      cyc(20);
      rst_b = 1;
      cyc(3);
      test_powerdown();
      test_presets();
      test_plug();
      test_straps();
      test_usb();
      end_sim();
   end
   initial
   begin
      #60000;
      bad_count++;
      $display("ERROR watchdog expected finish seen timeout");
      end_sim();
   end
endmodule : tb_top
bind lane_ctrl lane_ctrl_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_chk (.clk(clk), .rst_b(rst_b),
   .chip_enable(chip_enable), .reg_ctrl_sel(reg_ctrl_sel), .reg_preset(reg_preset),
   .sink_plug_detect_in(sink_plug_detect_in), .plug_active_low(plug_active_low),
   .plug_pin_bypass_n(plug_pin_bypass_n), .sig_active(sig_active), .pair_route(pair_route),
   .aux_swap(aux_swap), .aux_connect(aux_connect), .lane_out_en(lane_out_en),
   .usb_active(usb_active), .in_term(in_term), .out_term(out_term),
   .display_standby(display_standby));
